// file: core/rsc_pkg.sv
// Package of constants and types for the multi-source reset controller.
package rsc_pkg;

    // ----------
    // Register map (byte addresses)
    // ----------
    localparam logic [7:0] RSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] RSC_STATUS_ADDR = 8'h04;
    localparam logic [7:0] RSC_HRCW_ADDR = 8'h08;
    localparam logic [7:0] RSC_PORCFG_ADDR = 8'h0c;
    localparam logic [7:0] RSC_CAUSE_ADDR = 8'h10;

    // ----------
    // Control register fields
    // ----------
    localparam int RSC_CTRL_WDOG_EN_BIT = 0;
    localparam int RSC_CTRL_BMON_EN_BIT = 1;
    localparam int RSC_CTRL_SW_HARD_BIT = 2;
    localparam int RSC_CTRL_SW_SOFT_BIT = 3;

    // ----------
    // Cause register fields (sticky, write one to clear)
    // ----------
    localparam int RSC_CAUSE_POR_BIT = 0;
    localparam int RSC_CAUSE_HARD_EXT_BIT = 1;
    localparam int RSC_CAUSE_WDOG_BIT = 2;
    localparam int RSC_CAUSE_BMON_BIT = 3;
    localparam int RSC_CAUSE_SOFT_EXT_BIT = 4;
    localparam int RSC_CAUSE_HOST_BIT = 5;
    localparam int RSC_CAUSE_SCAN_BIT = 6;
    localparam int RSC_CAUSE_W = 7;

    // ----------
    // Reset values and timing
    // ----------
    localparam logic [31:0] RSC_HRCW_RESET = 32'h0000_0000;
    localparam logic [3:0] RSC_CTRL_RESET = 4'h0;
    localparam int RSC_CLK_MHZ = 40;
    localparam int RSC_POR_MIN_CYC = 16;
    localparam int RSC_HARD_HOLD_NS = 400;
    localparam int RSC_SOFT_HOLD_NS = 200;
    localparam int RSC_HARD_HOLD_CYC = (RSC_HARD_HOLD_NS * RSC_CLK_MHZ + 999) / 1000;
    localparam int RSC_SOFT_HOLD_CYC = (RSC_SOFT_HOLD_NS * RSC_CLK_MHZ + 999) / 1000;
    localparam int RSC_CNT_W = 8;

    // ----------
    // Reset sequencer states and kinds
    // ----------
    typedef enum logic [1:0] {
        RSC_ST_IDLE = 2'b00,
        RSC_ST_POR = 2'b01,
        RSC_ST_HARD = 2'b10,
        RSC_ST_SOFT = 2'b11
    } rsc_state_t;

    // Boundary-scan commands; any but RSC_SCAN_NONE forces a soft reset.
    typedef enum logic [1:0] {
        RSC_SCAN_NONE = 2'b00,
        RSC_SCAN_EXTEST = 2'b01,
        RSC_SCAN_CLAMP = 2'b10,
        RSC_SCAN_HIGHZ = 2'b11
    } rsc_scan_t;

    // Configuration latched only at power-on.
    typedef struct packed {
        logic [2:0] clock_mode_bits;
        logic [1:0] rst_cfg_mode;
        logic [1:0] boot_mode;
        logic [3:0] chip_id;
        logic host_port_64;
        logic [2:0] core_out_ratio;
    } rsc_porcfg_t;

    localparam int RSC_PORCFG_W = $bits(rsc_porcfg_t);

endpackage : rsc_pkg

// file: core/rsc_axil.sv
// AXI4-Lite register slave for the reset controller.
`timescale 1ns/1ps
`default_nettype none
module rsc_axil
    import rsc_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic wr_en, // One-cycle write strobe.
    output logic [7:0] wr_addr, // Write address.
    output logic [31:0] wr_data, // Write data as received; byte strobes not applied.
    output logic [3:0] wr_strb, // Write byte strobes.
    input wire logic wr_ok, // Address is writable.
    output logic [7:0] rd_addr, // Read address, combinational.
    input wire logic [31:0] rd_data, // Read data for rd_addr.
    input wire logic rd_ok // Address is readable.
);

    typedef struct packed {
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wr_en;
        logic awready, wready, arready;
    } rsc_axil_t;

    rsc_axil_t s_q;
    rsc_axil_t s_d;

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_arready = s_q.arready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign wr_en = s_q.wr_en;
    assign wr_addr = s_q.awaddr;
    assign wr_data = s_q.wdata;
    assign wr_strb = s_q.wstrb;
    assign rd_addr = s_axi_araddr;

    always_comb begin
        s_d = s_q;
        s_d.wr_en = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        // Both halves held: raise the response, and the write strobe when wr_ok, in the same cycle.
        if (s_q.aw_have && s_q.w_have) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.wr_en = wr_ok;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_ok ? 2'b00 : 2'b10;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_ok ? rd_data : 32'h0000_0000;
            s_d.rresp = rd_ok ? 2'b00 : 2'b10;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : rsc_axil
`default_nettype wire

// file: core/rsc_top.sv
// Multi-source reset controller: sources, priority, pin drive and reset outputs.
`timescale 1ns/1ps
`default_nettype none
module rsc_top
    import rsc_pkg::*;
#(
    parameter int HARD_HOLD = RSC_HARD_HOLD_CYC, // Cycles a hard reset stays driven.
    parameter int SOFT_HOLD = RSC_SOFT_HOLD_CYC, // Cycles a soft reset stays driven.
    parameter int POR_HOLD = RSC_POR_MIN_CYC // Cycles after power-on input release.
)
(
    input wire logic clk, // Input reference clock, 40 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic power_on_reset_in_n, // Power-on reset pin, active low.
    input wire logic hard_reset_pin_i, // Hard reset pin level in.
    output logic hard_reset_pin_o, // Hard reset pin drive value, always low.
    output logic hard_reset_pin_oe, // Hard reset pin drive enable.
    input wire logic soft_reset_pin_i, // Soft reset pin level in.
    output logic soft_reset_pin_o, // Soft reset pin drive value, always low.
    output logic soft_reset_pin_oe, // Soft reset pin drive enable.
    input wire logic wdog_zero, // Watchdog count reached zero, same clock.
    input wire logic bmon_zero, // Bus monitor count reached zero, same clock.
    input wire logic host_soft_cmd, // Host reset command from test port.
    input wire logic [1:0] scan_cmd, // Active boundary-scan command.
    input wire logic [RSC_PORCFG_W-1:0] cfg_pins, // Configuration straps.
    input wire logic host_cfg_valid, // Host-port configuration write.
    input wire logic [31:0] host_cfg_word, // Host-port configuration word.
    output logic system_pll_rst, // System PLL state reset.
    output logic bus_interface_unit_rst, // Bus interface unit register reset.
    output logic peripheral_bus_rst, // Peripheral bus module reset.
    output logic core_rst, // Core reset.
    output logic internal_bus_subsystem_rst, // Internal bus reset.
    output logic [RSC_PORCFG_W-1:0] porcfg, // Configuration latched at power-on.
    output logic [31:0] hrcw, // Hard reset configuration word.
    input wire logic [7:0] s_axi_awaddr, // AXI write address.
    input wire logic s_axi_awvalid, // AXI write address valid.
    output logic s_axi_awready, // AXI write address ready.
    input wire logic [31:0] s_axi_wdata, // AXI write data.
    input wire logic [3:0] s_axi_wstrb, // AXI write strobes.
    input wire logic s_axi_wvalid, // AXI write data valid.
    output logic s_axi_wready, // AXI write data ready.
    output logic [1:0] s_axi_bresp, // AXI write response.
    output logic s_axi_bvalid, // AXI write response valid.
    input wire logic s_axi_bready, // AXI write response ready.
    input wire logic [7:0] s_axi_araddr, // AXI read address.
    input wire logic s_axi_arvalid, // AXI read address valid.
    output logic s_axi_arready, // AXI read address ready.
    output logic [31:0] s_axi_rdata, // AXI read data.
    output logic [1:0] s_axi_rresp, // AXI read response.
    output logic s_axi_rvalid, // AXI read data valid.
    input wire logic s_axi_rready // AXI read data ready.
);

    // ----------
    // State
    // ----------
    typedef struct packed {
        logic [1:0] por_sync;
        logic [1:0] hard_sync;
        logic [1:0] soft_sync;
        logic [1:0] host_sync;
        logic [1:0][RSC_PORCFG_W-1:0] cfg_sync;
        logic hard_seen;
        logic soft_seen;
        rsc_state_t st;
        logic [RSC_CNT_W-1:0] cnt;
        logic [3:0] ctrl;
        logic [RSC_CAUSE_W-1:0] cause;
        logic [31:0] hrcw;
        logic [RSC_PORCFG_W-1:0] porcfg;
        logic scan_soft_drive;
        logic pll_rst;
        logic biu_rst;
        logic per_rst;
        logic core_rst;
        logic ibus_rst;
        logic hard_oe;
        logic soft_oe;
    } rsc_top_t;

    rsc_top_t s_q;
    rsc_top_t s_d;

    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;

    // Byte-lane merge used for the control and configuration word registers.
    function automatic logic [31:0] rsc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : rsc_merge

    function automatic logic [RSC_CNT_W-1:0] rsc_cyc(input int n);
        return RSC_CNT_W'((n < 1) ? 1 : n);
    endfunction : rsc_cyc

    // ----------
    // Register bus
    // ----------
    rsc_axil u_axil (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    assign wr_ok = (wr_addr == RSC_CTRL_ADDR) || (wr_addr == RSC_HRCW_ADDR)
                || (wr_addr == RSC_CAUSE_ADDR);
    assign rd_ok = (rd_addr == RSC_CTRL_ADDR) || (rd_addr == RSC_STATUS_ADDR)
                || (rd_addr == RSC_HRCW_ADDR) || (rd_addr == RSC_PORCFG_ADDR)
                || (rd_addr == RSC_CAUSE_ADDR);

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            RSC_CTRL_ADDR: rd_data = {28'h000_0000, s_q.ctrl};
            RSC_STATUS_ADDR: rd_data = {24'h00_0000, s_q.hard_oe, s_q.soft_oe,
                                        s_q.per_rst, s_q.biu_rst, s_q.pll_rst,
                                        s_q.core_rst, s_q.st};
            RSC_HRCW_ADDR: rd_data = s_q.hrcw;
            RSC_PORCFG_ADDR: rd_data = 32'(s_q.porcfg);
            RSC_CAUSE_ADDR: rd_data = 32'(s_q.cause);
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ----------
    // Sequencer
    // ----------
    always_comb begin
        logic por_req;
        logic hard_ext;
        logic wd_req;
        logic bm_req;
        logic hard_req;
        logic soft_ext;
        logic host_req;
        logic scan_req;
        logic soft_req;
        logic busy;
        logic [RSC_CAUSE_W-1:0] set_c;
        logic [31:0] m;
        por_req = 1'b0;
        hard_ext = 1'b0;
        wd_req = 1'b0;
        bm_req = 1'b0;
        hard_req = 1'b0;
        soft_ext = 1'b0;
        host_req = 1'b0;
        scan_req = 1'b0;
        soft_req = 1'b0;
        busy = 1'b0;
        set_c = '0;
        m = 32'h0000_0000;
        s_d = s_q;

        // Pins pass two flops before use.
        s_d.por_sync = {s_q.por_sync[0], ~power_on_reset_in_n};
        s_d.hard_sync = {s_q.hard_sync[0], ~hard_reset_pin_i};
        s_d.soft_sync = {s_q.soft_sync[0], ~soft_reset_pin_i};
        s_d.host_sync = {s_q.host_sync[0], host_soft_cmd};
        s_d.cfg_sync = {s_q.cfg_sync[0], cfg_pins};
        s_d.hard_seen = s_q.hard_sync[1];
        s_d.soft_seen = s_q.soft_sync[1];

        busy = (s_q.st != RSC_ST_IDLE);
        por_req = s_q.por_sync[1];
        // Our own drive shows on the pin; only a fresh edge while idle counts.
        hard_ext = s_q.hard_sync[1] && !s_q.hard_seen && !busy;
        wd_req = wdog_zero && s_q.ctrl[RSC_CTRL_WDOG_EN_BIT];
        bm_req = bmon_zero && s_q.ctrl[RSC_CTRL_BMON_EN_BIT];
        hard_req = hard_ext || wd_req || bm_req;
        soft_ext = s_q.soft_sync[1] && !s_q.soft_seen && !busy;
        host_req = s_q.host_sync[1];
        scan_req = (scan_cmd != RSC_SCAN_NONE);
        soft_req = soft_ext || host_req || scan_req;

        if (wr_en && wr_addr == RSC_CTRL_ADDR) begin
            m = rsc_merge(32'(s_q.ctrl), wr_data, wr_strb);
            s_d.ctrl = m[3:0];
            hard_req = hard_req || m[RSC_CTRL_SW_HARD_BIT];
            soft_req = soft_req || m[RSC_CTRL_SW_SOFT_BIT];
            s_d.ctrl[RSC_CTRL_SW_HARD_BIT] = 1'b0;
            s_d.ctrl[RSC_CTRL_SW_SOFT_BIT] = 1'b0;
        end
        // Bus config write taken only in power-on or hard reset.
        if (wr_en && wr_addr == RSC_HRCW_ADDR
            && (s_q.st == RSC_ST_POR || s_q.st == RSC_ST_HARD)) begin
            s_d.hrcw = rsc_merge(s_q.hrcw, wr_data, wr_strb);
        end
        if (host_cfg_valid && s_q.st == RSC_ST_POR) begin
            s_d.hrcw = host_cfg_word;
        end

        set_c[RSC_CAUSE_POR_BIT] = por_req;
        set_c[RSC_CAUSE_HARD_EXT_BIT] = hard_ext;
        set_c[RSC_CAUSE_WDOG_BIT] = wd_req;
        set_c[RSC_CAUSE_BMON_BIT] = bm_req;
        set_c[RSC_CAUSE_SOFT_EXT_BIT] = soft_ext;
        set_c[RSC_CAUSE_HOST_BIT] = host_req;
        set_c[RSC_CAUSE_SCAN_BIT] = scan_req;
        // Setting wins over a write-one clear in the same cycle.
        if (wr_en && wr_addr == RSC_CAUSE_ADDR && wr_strb[0]) begin
            s_d.cause = s_q.cause & ~wr_data[RSC_CAUSE_W-1:0];
        end
        s_d.cause = s_d.cause | set_c;

        if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - RSC_CNT_W'(1);
        end

        // Priority: power-on over hard over soft; soft may not preempt a hard one.
        if (por_req) begin
            s_d.st = RSC_ST_POR;
            s_d.cnt = rsc_cyc(POR_HOLD);
            s_d.hrcw = RSC_HRCW_RESET;
            // Straps and clock ratio follow the pins only at power-on.
            s_d.porcfg = s_q.cfg_sync[1];
        end else if (hard_req && s_q.st != RSC_ST_POR) begin
            s_d.st = RSC_ST_HARD;
            s_d.cnt = rsc_cyc(HARD_HOLD);
        end else if (soft_req && !busy) begin
            s_d.st = RSC_ST_SOFT;
            s_d.cnt = rsc_cyc(SOFT_HOLD);
            s_d.scan_soft_drive = (scan_cmd != RSC_SCAN_HIGHZ);
            if (soft_ext || host_req || !scan_req) begin
                s_d.scan_soft_drive = 1'b1;
            end
        end else if (busy && s_q.cnt == '0) begin
            s_d.st = RSC_ST_IDLE;
        end

        // Outputs follow the state that is being entered.
        s_d.pll_rst = (s_d.st == RSC_ST_POR);
        s_d.biu_rst = (s_d.st == RSC_ST_POR) || (s_d.st == RSC_ST_HARD);
        s_d.hard_oe = (s_d.st == RSC_ST_POR) || (s_d.st == RSC_ST_HARD);
        s_d.core_rst = (s_d.st != RSC_ST_IDLE);
        s_d.per_rst = (s_d.st != RSC_ST_IDLE);
        s_d.ibus_rst = (s_d.st != RSC_ST_IDLE);
        // Hard drive always carries soft drive with it.
        s_d.soft_oe = s_d.hard_oe
                   || (s_d.st == RSC_ST_SOFT && s_d.scan_soft_drive);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= RSC_ST_POR;
            s_q.cnt <= rsc_cyc(POR_HOLD);
            s_q.ctrl <= RSC_CTRL_RESET;
            s_q.hrcw <= RSC_HRCW_RESET;
            s_q.pll_rst <= 1'b1;
            s_q.biu_rst <= 1'b1;
            s_q.per_rst <= 1'b1;
            s_q.core_rst <= 1'b1;
            s_q.ibus_rst <= 1'b1;
            s_q.hard_oe <= 1'b1;
            s_q.soft_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hard_reset_pin_o = 1'b0;
    assign soft_reset_pin_o = 1'b0;
    assign hard_reset_pin_oe = s_q.hard_oe;
    assign soft_reset_pin_oe = s_q.soft_oe;
    assign system_pll_rst = s_q.pll_rst;
    assign bus_interface_unit_rst = s_q.biu_rst;
    assign peripheral_bus_rst = s_q.per_rst;
    assign core_rst = s_q.core_rst;
    assign internal_bus_subsystem_rst = s_q.ibus_rst;
    assign porcfg = s_q.porcfg;
    assign hrcw = s_q.hrcw;

endmodule : rsc_top
`default_nettype wire

// file: bench/rsc_checker.sv
// Concurrent checks on the reset controller's outputs.
`timescale 1ns/1ps
`default_nettype none
module rsc_checker
    import rsc_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic hard_reset_pin_oe, // Hard pin drive.
    input wire logic soft_reset_pin_oe, // Soft pin drive.
    input wire logic system_pll_rst, // PLL reset.
    input wire logic bus_interface_unit_rst, // Bus unit reset.
    input wire logic peripheral_bus_rst, // Peripheral reset.
    input wire logic core_rst, // Core reset.
    input wire logic internal_bus_subsystem_rst, // Internal bus reset.
    input wire logic [RSC_PORCFG_W-1:0] porcfg, // Latched straps.
    input wire logic [31:0] hrcw // Configuration word.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_HARD_SOFT: assert property (hard_reset_pin_oe |-> soft_reset_pin_oe)
        else $error("hard pin driven without soft pin");
    AST_BIU_HARD: assert property (bus_interface_unit_rst == hard_reset_pin_oe)
        else $error("bus unit reset and hard pin drive differ");
    AST_PLL_POR: assert property (system_pll_rst |-> bus_interface_unit_rst)
        else $error("pll reset outside a power-on reset");
    AST_ALL_SRC: assert property (core_rst == peripheral_bus_rst && core_rst == internal_bus_subsystem_rst)
        else $error("core, peripheral and internal bus resets differ");
    AST_SOFT_CORE: assert property (soft_reset_pin_oe |-> core_rst)
        else $error("soft pin driven without core reset");
    AST_CFG_HOLD: assert property (!system_pll_rst && !$past(system_pll_rst) |-> $stable(porcfg))
        else $error("latched configuration changed after power-on");
    AST_HRCW_HOLD: assert property (!(bus_interface_unit_rst || $past(bus_interface_unit_rst)
        || $past(bus_interface_unit_rst, 2)) |-> $stable(hrcw))
        else $error("configuration word changed outside hard reset");
    AST_SOFT_LEN: assert property ($rose(soft_reset_pin_oe) |-> soft_reset_pin_oe [*8])
        else $error("soft pin drive too short");
    AST_HARD_LEN: assert property ($rose(hard_reset_pin_oe) |-> hard_reset_pin_oe [*8])
        else $error("hard pin drive too short");
    COV_HARD: cover property ($rose(hard_reset_pin_oe));
    COV_SOFT: cover property ($rose(soft_reset_pin_oe) && !hard_reset_pin_oe);
    COV_QUIET: cover property ($rose(core_rst) && !soft_reset_pin_oe);
endmodule : rsc_checker
`default_nettype wire

// file: bench/rsc_board.sv
// Board side: power-on supervisor and the pulled-up open-drain reset pins.
`timescale 1ns/1ps
`default_nettype none
module rsc_board (
    input wire logic clk, // Free-running reference clock.
    input wire logic hard_oe, // Device pulls the hard pin low.
    input wire logic soft_oe, // Device pulls the soft pin low.
    input wire logic hard_req, // Board pulls the hard pin low.
    input wire logic soft_req, // Board pulls the soft pin low.
    output logic por_n, // Power-on reset input.
    output logic hard_lvl, // Hard pin wire level.
    output logic soft_lvl // Soft pin wire level.
);
    int cnt = 0;
    // Power-on input stays low for 24 clocks of a free-running clock.
    always @(posedge clk) begin
        if (cnt < 24) cnt <= cnt + 1;
    end
    assign por_n = (cnt >= 24);
    // Pull-ups: a pin reads high unless some party drives it.
    assign hard_lvl = !(hard_oe || hard_req);
    assign soft_lvl = !(soft_oe || soft_req);
endmodule : rsc_board
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the multi-source reset controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rsc_pkg::*;
;
    localparam logic [RSC_PORCFG_W-1:0] CFG = 15'h5a3c;
    logic clk = 1'b0;
    logic rst, wdog_zero, bmon_zero, host_soft_cmd, host_cfg_valid, hard_req, soft_req;
    logic power_on_reset_in_n, hard_reset_pin_i, soft_reset_pin_i, hard_reset_pin_oe;
    logic soft_reset_pin_oe, system_pll_rst, bus_interface_unit_rst, peripheral_bus_rst;
    logic core_rst, internal_bus_subsystem_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] scan_cmd, s_axi_bresp, s_axi_rresp, rs_q;
    logic [RSC_PORCFG_W-1:0] cfg_pins, porcfg;
    logic [31:0] host_cfg_word, hrcw, s_axi_wdata, s_axi_rdata;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    int num_errors = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    rsc_board brd (.clk, .hard_oe(hard_reset_pin_oe), .soft_oe(soft_reset_pin_oe), .hard_req,
        .soft_req, .por_n(power_on_reset_in_n), .hard_lvl(hard_reset_pin_i),
        .soft_lvl(soft_reset_pin_i));
    rsc_top uut (.clk, .rst, .power_on_reset_in_n, .hard_reset_pin_i, .hard_reset_pin_o(),
        .hard_reset_pin_oe, .soft_reset_pin_i, .soft_reset_pin_o(), .soft_reset_pin_oe,
        .wdog_zero, .bmon_zero, .host_soft_cmd, .scan_cmd, .cfg_pins, .host_cfg_valid,
        .host_cfg_word, .system_pll_rst, .bus_interface_unit_rst, .peripheral_bus_rst, .core_rst,
        .internal_bus_subsystem_rst, .porcfg, .hrcw, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] h;
        h = 3'b000;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        for (int n = 0; !h[0]; n++) begin
            if (n == 300) begin num_errors++; finish_test(); end
            @(posedge clk);
            h = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready, s_axi_bvalid};
            if (h[2]) s_axi_awvalid <= 1'b0;
            if (h[1]) s_axi_wvalid <= 1'b0;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [1:0] h;
        logic [31:0] q;
        h = 2'b00;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; !h[0]; n++) begin
            if (n == 300) begin num_errors++; finish_test(); end
            @(posedge clk);
            h = {s_axi_arvalid && s_axi_arready, s_axi_rvalid};
            q = s_axi_rdata;
            rs_q = s_axi_rresp;
            if (h[1]) s_axi_arvalid <= 1'b0;
        end
        chk(q, exp);
    endtask : rd
    task automatic wait_core(input logic want);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 400) begin num_errors++; finish_test(); end
        end while (core_rst !== want);
    endtask : wait_core
    // A board pulse on the soft pin while busy must go unseen.
    task automatic src(input int b, input logic eh, input logic es);
        wait_core(1'b1);
        chk(hard_reset_pin_oe, eh);
        chk(soft_reset_pin_oe, es);
        @(posedge clk);
        {wdog_zero, bmon_zero, host_soft_cmd, scan_cmd, hard_req, soft_req} <= 7'h01;
        @(posedge clk);
        soft_req <= 1'b0;
        wait_core(1'b0);
        @(posedge clk);
        rd(RSC_CAUSE_ADDR, 32'h1 << b);
        wr(RSC_CAUSE_ADDR, 32'h7f);
        chk(porcfg, CFG);
    endtask : src
    task automatic s_hard();
        hard_req <= 1'b1;
        wait_core(1'b1);
        @(posedge clk);
        wr(RSC_HRCW_ADDR, 32'hc3a5_9612);
        rd(RSC_HRCW_ADDR, 32'hc3a5_9612);
        src(RSC_CAUSE_HARD_EXT_BIT, 1'b1, 1'b1);
    endtask : s_hard
    task automatic s_wdog_bmon();
        wdog_zero <= 1'b1;
        repeat (10) @(negedge clk);
        chk(core_rst, 1'b0);
        @(posedge clk);
        wr(RSC_CTRL_ADDR, 32'h3);
        src(RSC_CAUSE_WDOG_BIT, 1'b1, 1'b1);
        wr(RSC_CTRL_ADDR, 32'h3);
        bmon_zero <= 1'b1;
        src(RSC_CAUSE_BMON_BIT, 1'b1, 1'b1);
    endtask : s_wdog_bmon
    task automatic s_soft();
        soft_req <= 1'b1;
        src(RSC_CAUSE_SOFT_EXT_BIT, 1'b0, 1'b1);
        host_soft_cmd <= 1'b1;
        src(RSC_CAUSE_HOST_BIT, 1'b0, 1'b1);
        for (int c = 1; c < 4; c++) begin
            scan_cmd <= 2'(c);
            src(RSC_CAUSE_SCAN_BIT, 1'b0, c != 3);
        end
    endtask : s_soft
    task automatic s_regs();
        {host_cfg_valid, host_cfg_word} <= {1'b1, 32'h1234_5678};
        wr(RSC_HRCW_ADDR, 32'hc3a5_9612);
        rd(RSC_HRCW_ADDR, RSC_HRCW_RESET);
        chk(hrcw, RSC_HRCW_RESET);
        host_cfg_valid <= 1'b0;
        rd(8'h40, 32'h0);
        chk(rs_q, 2'b10);
    endtask : s_regs
    initial begin
        {rst, wdog_zero, bmon_zero, host_soft_cmd, host_cfg_valid, hard_req, soft_req} = 7'h40;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
        {scan_cmd, host_cfg_word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        cfg_pins = CFG;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wait_core(1'b0);
        @(posedge clk);
        cfg_pins <= ~CFG;
        chk(porcfg, CFG);
        rd(RSC_CAUSE_ADDR, 32'h1);
        wr(RSC_CAUSE_ADDR, 32'h7f);
        s_regs();
        s_hard();
        s_wdog_bmon();
        s_soft();
        finish_test();
    end
endmodule : tb_top
bind rsc_top rsc_checker chk_i (.clk, .rst, .hard_reset_pin_oe, .soft_reset_pin_oe,
    .system_pll_rst, .bus_interface_unit_rst, .peripheral_bus_rst, .core_rst,
    .internal_bus_subsystem_rst, .porcfg, .hrcw);
`default_nettype wire
